// ---- verilog/mpg_gpio.sv ----
// Three-port general purpose I/O block with alternate functions
// Overview of operation
// - A first-port line whose open-drain bit is 1 drives only low.
// - First-port lines 4 to 7 carry capture/compare channels 28 to 31.
// - Capture pins of both byte ports are sampled every 200 ns as interrupt inputs.
// - First-port lines 0 to 3 carry PWM channels 0 to 3.
// - A PWM pin shows the PWM level XOR the port latch.
// - A second-port direction bit of 0 makes the line an input, 1 an output.
// - Each second-port line is push-pull or open-drain per its open-drain bit.
// - Second-port lines 0 to 7 carry capture/compare channels 16 to 23.
// - Second-port compare data is merged into the latch input, not after it.
// - Wide-port registers take whole-word accesses only.
// - Each wide-port line takes its direction from its direction bit.
// - Each wide-port line is push-pull or open-drain per its open-drain bit.
// - Writing 1 to a set or clear register sets or clears that bit; 0 does nothing.
`default_nettype none
`include "mpg_defs.svh"
module mpg_gpio
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Register port
   input wire logic [15:0] BUS_ADDR,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   input wire logic [1:0] BUS_BE,
   input wire logic [15:0] BUS_WDATA,
   output logic [15:0] BUS_RDATA,
   // Wide port enables
   input wire logic EXT_PERIPH_EN,
   input wire logic WIDE_PORT_EN,
   // Alternate functions
   input wire logic [3:0] PWM_OUT,
   input wire logic [3:0] CC_FIRST_OUT,
   input wire logic [7:0] CC_SECOND_WE,
   input wire logic [7:0] CC_SECOND_D,
   output logic [3:0] CAPTURE_FIRST,
   output logic [7:0] CAPTURE_SECOND,
   // First port pins
   input wire logic [7:0] FIRST_PORT_IN,
   output logic [7:0] FIRST_PORT_OUT,
   output logic [7:0] FIRST_PORT_OE,
   // Second port pins
   input wire logic [7:0] SECOND_PORT_IN,
   output logic [7:0] SECOND_PORT_OUT,
   output logic [7:0] SECOND_PORT_OE,
   // Wide port pins
   input wire logic [15:0] WIDE_PORT_IN,
   output logic [15:0] WIDE_PORT_OUT,
   output logic [15:0] WIDE_PORT_OE
);
   localparam int SAMPLE_CYC = `MPG_SAMPLE_CYC;

   mpg_pkg::mpg_byte_t fp_data_reg, fp_dir_reg, fp_od_reg;
   mpg_pkg::mpg_byte_t sp_data_reg, sp_dir_reg, sp_od_reg;
   mpg_pkg::mpg_word_t wp_data_reg, wp_dir_reg, wp_od_reg;
   logic [31:0] pin_meta_reg, pin_sync_reg;
   logic [2:0] smp_cnt_reg;
   logic smp_tick;
   logic wp_on, wp_acc;
   logic [7:0] fp_level;
   logic [7:0] sp_wr;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic mpg_pkg::mpg_word_t apply_op(input mpg_pkg::mpg_word_t cur,
      input mpg_pkg::mpg_word_t wd, input mpg_pkg::mpg_op_t op);
      case (op)
         mpg_pkg::MPG_OP_WRITE: apply_op = wd;
         mpg_pkg::MPG_OP_SET: apply_op = cur | wd;
         mpg_pkg::MPG_OP_CLR: apply_op = cur & ~wd;
         default: apply_op = cur;
      endcase
   endfunction : apply_op

   // Output enable: off for inputs, and for open-drain lines at high level
   function automatic mpg_pkg::mpg_word_t drive_oe(input mpg_pkg::mpg_word_t lvl,
      input mpg_pkg::mpg_word_t dir, input mpg_pkg::mpg_word_t od);
      drive_oe = dir & ~(od & lvl);
   endfunction : drive_oe

   function automatic mpg_pkg::mpg_op_t wp_decode(input logic [15:0] a,
      input logic [15:0] base);
      if (a == base)
         wp_decode = mpg_pkg::MPG_OP_WRITE;
      else if (a == base + 16'h0002)
         wp_decode = mpg_pkg::MPG_OP_SET;
      else if (a == base + 16'h0004)
         wp_decode = mpg_pkg::MPG_OP_CLR;
      else
         wp_decode = mpg_pkg::mpg_op_t'(3'h0);
   endfunction : wp_decode

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         pin_meta_reg <= 32'h00000000;
         pin_sync_reg <= 32'h00000000;
      end
      else
      begin
         pin_meta_reg <= {WIDE_PORT_IN, SECOND_PORT_IN, FIRST_PORT_IN};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Capture sampling
   // ----------------------------------------------------------------
   assign smp_tick = (smp_cnt_reg == 3'(SAMPLE_CYC - 1));

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         smp_cnt_reg <= 3'h0;
      else if (smp_tick)
         smp_cnt_reg <= 3'h0;
      else
         smp_cnt_reg <= smp_cnt_reg + 3'h1;
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         CAPTURE_FIRST <= 4'h0;
         CAPTURE_SECOND <= 8'h00;
      end
      else if (smp_tick)
      begin
         CAPTURE_FIRST <= pin_sync_reg[7:4];
         CAPTURE_SECOND <= pin_sync_reg[15:8];
      end
   end

   // ----------------------------------------------------------------
   // First port registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         fp_data_reg <= `MPG_BYTE_RESET;
         fp_dir_reg <= `MPG_BYTE_RESET;
         fp_od_reg <= `MPG_BYTE_RESET;
      end
      else if (BUS_WR && BUS_BE[0])
      begin
         if (BUS_ADDR == `MPG_FP_DATA_ADDR)
            fp_data_reg <= BUS_WDATA[7:0];
         if (BUS_ADDR == `MPG_FP_DIR_ADDR)
            fp_dir_reg <= BUS_WDATA[7:0];
         if (BUS_ADDR == `MPG_FP_OD_ADDR)
            fp_od_reg <= BUS_WDATA[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Second port registers
   // ----------------------------------------------------------------
   assign sp_wr = (BUS_WR && BUS_BE[0] && BUS_ADDR == `MPG_SP_DATA_ADDR) ? 8'hFF : 8'h00;

   // Compare data enters ahead of the latch and wins over a bus write
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         sp_data_reg <= `MPG_BYTE_RESET;
      else
         sp_data_reg <= (CC_SECOND_WE & CC_SECOND_D)
            | (~CC_SECOND_WE & sp_wr & BUS_WDATA[7:0])
            | (~CC_SECOND_WE & ~sp_wr & sp_data_reg);
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         sp_dir_reg <= `MPG_BYTE_RESET;
         sp_od_reg <= `MPG_BYTE_RESET;
      end
      else if (BUS_WR && BUS_BE[0])
      begin
         if (BUS_ADDR == `MPG_SP_DIR_ADDR)
            sp_dir_reg <= BUS_WDATA[7:0];
         if (BUS_ADDR == `MPG_SP_OD_ADDR)
            sp_od_reg <= BUS_WDATA[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Wide port registers
   // ----------------------------------------------------------------
   assign wp_on = EXT_PERIPH_EN && WIDE_PORT_EN;
   assign wp_acc = wp_on && BUS_BE == `MPG_BE_WORD;

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         wp_data_reg <= `MPG_WORD_RESET;
         wp_dir_reg <= `MPG_WORD_RESET;
         wp_od_reg <= `MPG_WORD_RESET;
      end
      else if (BUS_WR && wp_acc)
      begin
         wp_data_reg <= apply_op(wp_data_reg, BUS_WDATA,
            wp_decode(BUS_ADDR, `MPG_WP_DATA_ADDR));
         wp_dir_reg <= apply_op(wp_dir_reg, BUS_WDATA,
            wp_decode(BUS_ADDR, `MPG_WP_DIR_ADDR));
         wp_od_reg <= apply_op(wp_od_reg, BUS_WDATA,
            wp_decode(BUS_ADDR, `MPG_WP_OD_ADDR));
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         BUS_RDATA <= 16'h0000;
      else if (BUS_RD)
      begin
         case (BUS_ADDR)
            `MPG_FP_DATA_ADDR: BUS_RDATA <= {8'h00, pin_sync_reg[7:0]};
            `MPG_FP_DIR_ADDR: BUS_RDATA <= {8'h00, fp_dir_reg};
            `MPG_FP_OD_ADDR: BUS_RDATA <= {8'h00, fp_od_reg};
            `MPG_SP_DATA_ADDR: BUS_RDATA <= {8'h00, pin_sync_reg[15:8]};
            `MPG_SP_DIR_ADDR: BUS_RDATA <= {8'h00, sp_dir_reg};
            `MPG_SP_OD_ADDR: BUS_RDATA <= {8'h00, sp_od_reg};
            `MPG_WP_DATA_ADDR: BUS_RDATA <= wp_acc ? pin_sync_reg[31:16] : 16'h0000;
            `MPG_WP_DIR_ADDR: BUS_RDATA <= wp_acc ? wp_dir_reg : 16'h0000;
            `MPG_WP_OD_ADDR: BUS_RDATA <= wp_acc ? wp_od_reg : 16'h0000;
            default: BUS_RDATA <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // PWM lines XOR the latch, compare lines AND it
   assign fp_level = {CC_FIRST_OUT & fp_data_reg[7:4],
      PWM_OUT ^ fp_data_reg[3:0]};

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         FIRST_PORT_OUT <= 8'h00;
         FIRST_PORT_OE <= 8'h00;
      end
      else
      begin
         FIRST_PORT_OUT <= fp_level;
         FIRST_PORT_OE <= 8'(drive_oe({8'h00, fp_level}, {8'h00, fp_dir_reg},
            {8'h00, fp_od_reg}));
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         SECOND_PORT_OUT <= 8'h00;
         SECOND_PORT_OE <= 8'h00;
      end
      else
      begin
         SECOND_PORT_OUT <= sp_data_reg;
         SECOND_PORT_OE <= 8'(drive_oe({8'h00, sp_data_reg}, {8'h00, sp_dir_reg},
            {8'h00, sp_od_reg}));
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         WIDE_PORT_OUT <= 16'h0000;
         WIDE_PORT_OE <= 16'h0000;
      end
      else
      begin
         WIDE_PORT_OUT <= wp_data_reg;
         WIDE_PORT_OE <= wp_on ? drive_oe(wp_data_reg, wp_dir_reg, wp_od_reg)
            : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   property p_first_od;
      ##1 (FIRST_PORT_OE & $past(fp_od_reg) & $past(fp_level)) == 8'h00;
   endproperty
   a_first_od: assert property (p_first_od) else $error("open-drain line driven high");
   property p_pwm_xor;
      ##1 FIRST_PORT_OUT[3:0] == ($past(PWM_OUT) ^ $past(fp_data_reg[3:0]));
   endproperty
   a_pwm_xor: assert property (p_pwm_xor) else $error("PWM pin not XOR of latch");
   property p_cc_first;
      ##1 FIRST_PORT_OUT[7:4] == ($past(CC_FIRST_OUT) & $past(fp_data_reg[7:4]));
   endproperty
   a_cc_first: assert property (p_cc_first) else $error("compare pin level wrong");
   property p_sample;
      !smp_tick |=> $stable(CAPTURE_SECOND) && $stable(CAPTURE_FIRST);
   endproperty
   a_sample: assert property (p_sample) else $error("capture changed off tick");
   property p_tick_gap;
      smp_tick |=> !smp_tick [*3] ##1 smp_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("sample spacing wrong");
   property p_sp_input;
      (sp_dir_reg == 8'h00) |=> SECOND_PORT_OE == 8'h00;
   endproperty
   a_sp_input: assert property (p_sp_input) else $error("input line driven");
   property p_sp_pushpull;
      ##1 (SECOND_PORT_OE == $past(sp_dir_reg & ~(sp_od_reg & sp_data_reg)));
   endproperty
   a_sp_pushpull: assert property (p_sp_pushpull) else $error("second port drive wrong");
   property p_cc_merge;
      CC_SECOND_WE[0] |=> sp_data_reg[0] == $past(CC_SECOND_D[0]) ##1
         SECOND_PORT_OUT[0] == $past(sp_data_reg[0]);
   endproperty
   a_cc_merge: assert property (p_cc_merge) else $error("compare data not latched");
   property p_wp_set;
      (BUS_WR && wp_acc && BUS_ADDR == `MPG_WP_DATA_SET_ADDR)
         |=> wp_data_reg == ($past(wp_data_reg) | $past(BUS_WDATA));
   endproperty
   a_wp_set: assert property (p_wp_set) else $error("set register failed");
   property p_wp_clr;
      (BUS_WR && wp_acc && BUS_ADDR == `MPG_WP_OD_CLR_ADDR)
         |=> wp_od_reg == ($past(wp_od_reg) & ~$past(BUS_WDATA));
   endproperty
   a_wp_clr: assert property (p_wp_clr) else $error("clear register failed");
   property p_wp_word;
      (BUS_WR && BUS_BE != `MPG_BE_WORD) |=> $stable(wp_data_reg) && $stable(wp_dir_reg);
   endproperty
   a_wp_word: assert property (p_wp_word) else $error("partial write took effect");
   property p_wp_off;
      !wp_on |=> WIDE_PORT_OE == 16'h0000 && $stable(wp_od_reg);
   endproperty
   a_wp_off: assert property (p_wp_off) else $error("disabled port active");
   property p_wp_dir;
      ##1 (WIDE_PORT_OE & ~$past(wp_dir_reg)) == 16'h0000;
   endproperty
   a_wp_dir: assert property (p_wp_dir) else $error("wide input line driven");
   property p_wp_od;
      ##1 (WIDE_PORT_OE & $past(wp_od_reg) & $past(wp_data_reg)) == 16'h0000;
   endproperty
   a_wp_od: assert property (p_wp_od) else $error("wide open-drain driven high");
   c_pwm_inv: cover property (fp_dir_reg[0] && fp_data_reg[0] && PWM_OUT[0]);
   c_cc_load: cover property (CC_SECOND_WE != 8'h00);
   c_wp_set: cover property (BUS_WR && wp_acc && BUS_ADDR == `MPG_WP_DIR_SET_ADDR);
   c_wp_off: cover property (BUS_WR && !wp_on && BUS_ADDR == `MPG_WP_DATA_ADDR);
endmodule : mpg_gpio
`default_nettype wire

// ---- pkg/mpg_defs.svh ----
// Register offsets, reset values and timing counts of the port block
`ifndef MPG_DEFS_SVH
`define MPG_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MPG_FP_DATA_ADDR 16'hFFD0
`define MPG_FP_DIR_ADDR 16'hFFD2
`define MPG_FP_OD_ADDR 16'hF1D2
`define MPG_SP_DATA_ADDR 16'hFFD4
`define MPG_SP_DIR_ADDR 16'hFFD6
`define MPG_SP_OD_ADDR 16'hF1D6
`define MPG_WP_DATA_ADDR 16'hC100
`define MPG_WP_DATA_SET_ADDR 16'hC102
`define MPG_WP_DATA_CLR_ADDR 16'hC104
`define MPG_WP_DIR_ADDR 16'hC200
`define MPG_WP_DIR_SET_ADDR 16'hC202
`define MPG_WP_DIR_CLR_ADDR 16'hC204
`define MPG_WP_OD_ADDR 16'hC300
`define MPG_WP_OD_SET_ADDR 16'hC302
`define MPG_WP_OD_CLR_ADDR 16'hC304
// ----------------------------------------------------------------
// Reset values and the whole-word byte-enable code
// ----------------------------------------------------------------
`define MPG_BYTE_RESET 8'h00
`define MPG_WORD_RESET 16'h0000
`define MPG_BE_WORD 2'h3
// ----------------------------------------------------------------
// Capture sampling interval
// ----------------------------------------------------------------
`define MPG_SAMPLE_NS 200
`define MPG_CLK_NS 50
`define MPG_SAMPLE_CYC ((`MPG_SAMPLE_NS) / (`MPG_CLK_NS))
`endif

// ---- pkg/mpg_pkg.sv ----
// Types shared by the port block
`default_nettype none
package mpg_pkg;
   typedef logic [7:0] mpg_byte_t;
   typedef logic [15:0] mpg_word_t;
   typedef enum logic [2:0]
   {
      MPG_OP_WRITE = 3'h1,
      MPG_OP_SET = 3'h2,
      MPG_OP_CLR = 3'h4
   } mpg_op_t;
endpackage : mpg_pkg
`default_nettype wire

// ---- dv/mpg_pin_model.sv ----
// Board-side model of the port pins: external drivers on released lines
`default_nettype none
module mpg_pin_model
#(
   parameter int W = 8
)
(
   // Device side
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] oe,
   // Board side
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // Released lines take the board-driven value ext_val
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         pin[i] = oe[i] ? out[i] : ext_val[i];
      end
   end
endmodule : mpg_pin_model
`default_nettype wire

// ---- dv/tb_mpg_gpio.sv ----
// Self-checking testbench of the three-port I/O block
`default_nettype none
`include "mpg_defs.svh"
module tb_mpg_gpio;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, ext_en = 1'h0, wide_en = 1'h0;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, win, wout, woe, wx = 16'hA5A5;
   logic [1:0] be = 2'h3;
   logic [3:0] pwm = 4'h0, cc1 = 4'h0, cap1;
   logic [7:0] ccwe = 8'h00, ccd = 8'h00, cap2, fin, fout, foe, sin, sout, soe;
   logic [7:0] fx = 8'hFF, sx = 8'hFF;
   int num_errors = 0, comparisons = 0;
   always #25 clk = ~clk;
   mpg_gpio i_mpg_gpio (.CLK(clk), .RSTN(rstn), .BUS_ADDR(addr), .BUS_WR(wr), .BUS_RD(rd),
      .BUS_BE(be), .BUS_WDATA(wdata), .BUS_RDATA(rdata), .EXT_PERIPH_EN(ext_en),
      .WIDE_PORT_EN(wide_en), .PWM_OUT(pwm), .CC_FIRST_OUT(cc1), .CC_SECOND_WE(ccwe),
      .CC_SECOND_D(ccd), .CAPTURE_FIRST(cap1), .CAPTURE_SECOND(cap2), .FIRST_PORT_IN(fin),
      .FIRST_PORT_OUT(fout), .FIRST_PORT_OE(foe), .SECOND_PORT_IN(sin),
      .SECOND_PORT_OUT(sout), .SECOND_PORT_OE(soe), .WIDE_PORT_IN(win),
      .WIDE_PORT_OUT(wout), .WIDE_PORT_OE(woe));
   mpg_pin_model #(.W(8)) i_mpg_pin_model_f (.out(fout), .oe(foe), .ext_val(fx), .pin(fin));
   mpg_pin_model #(.W(8)) i_mpg_pin_model_s (.out(sout), .oe(soe), .ext_val(sx), .pin(sin));
   mpg_pin_model #(.W(16)) i_mpg_pin_model_w (.out(wout), .oe(woe), .ext_val(wx), .pin(win));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrb(input logic [15:0] a, input logic [15:0] d, input logic [1:0] b);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      be <= b;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrb
   task automatic wrw(input logic [15:0] a, input logic [15:0] d);
      wrb(a, d, 2'h3);
   endtask : wrw
   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      be <= 2'h3;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : rdc
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      #1;
      check({fout, sout}, 16'h0000);
      check(woe, 16'h0000);
      @(posedge clk);
      ext_en <= 1'b1;
      wide_en <= 1'b1;
      rdc(`MPG_WP_DIR_ADDR, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_wide();
      wrw(`MPG_WP_DIR_ADDR, 16'h00FF);
      wrw(`MPG_WP_DATA_SET_ADDR, 16'h0105);
      wrw(`MPG_WP_DATA_CLR_ADDR, 16'h0004);
      wrw(`MPG_WP_OD_SET_ADDR, 16'h0003);
      wrw(`MPG_WP_OD_CLR_ADDR, 16'h0002);
      wrw(`MPG_WP_DIR_SET_ADDR, 16'h0100);
      wrw(`MPG_WP_DIR_CLR_ADDR, 16'h0080);
      wrb(`MPG_WP_DIR_ADDR, 16'hFFFF, 2'h1);
      settle();
      check(wout, 16'h0101);
      check(woe, 16'h017E);
      rdc(`MPG_WP_DIR_ADDR, 16'h017F);
      rdc(`MPG_WP_OD_ADDR, 16'h0001);
      rdc(`MPG_WP_DATA_SET_ADDR, 16'h0000);
      rdc(16'h1234, 16'h0000);
      rdc(`MPG_WP_DATA_ADDR, 16'hA581);
      @(posedge clk);
      ext_en <= 1'b0;
      wrw(`MPG_WP_DIR_SET_ADDR, 16'hFFFF);
      wrw(`MPG_WP_DATA_ADDR, 16'hFFFF);
      settle();
      check(woe, 16'h0000);
      rdc(`MPG_WP_DIR_ADDR, 16'h0000);
      @(posedge clk);
      ext_en <= 1'b1;
      rdc(`MPG_WP_DIR_ADDR, 16'h017F);
      check(wout, 16'h0101);
      $display("test wide port done");
   endtask : t_wide
   task automatic t_first();
      @(posedge clk);
      pwm <= 4'h5;
      cc1 <= 4'h9;
      wrw(`MPG_FP_DIR_ADDR, 16'h00FF);
      wrw(`MPG_FP_OD_ADDR, 16'h000F);
      wrw(`MPG_FP_DATA_ADDR, 16'h00F3);
      settle();
      check({8'h00, fout}, 16'h0096);
      check({8'h00, foe}, 16'h00F9);
      @(posedge clk);
      pwm <= 4'hA;
      settle();
      check({fout, foe}, 16'h99F6);
      $display("test first port done");
   endtask : t_first
   task automatic t_second();
      @(posedge clk);
      sx <= 8'h3C;
      wrw(`MPG_SP_DIR_ADDR, 16'h000F);
      wrw(`MPG_SP_OD_ADDR, 16'h0003);
      wrw(`MPG_SP_DATA_ADDR, 16'h00A5);
      settle();
      check({sout, soe}, 16'hA50E);
      rdc(`MPG_SP_DATA_ADDR, 16'h0034);
      @(posedge clk);
      ccwe <= 8'h81;
      ccd <= 8'h00;
      wr <= 1'b1;
      addr <= `MPG_SP_DATA_ADDR;
      wdata <= 16'h00FF;
      @(posedge clk);
      wr <= 1'b0;
      ccwe <= 8'h02;
      @(posedge clk);
      ccwe <= 8'h00;
      settle();
      check({8'h00, sout}, 16'h007C);
      $display("test second port done");
   endtask : t_second
   task automatic t_capture();
      @(posedge clk);
      fx <= 8'hA0;
      sx <= 8'h5A;
      wrw(`MPG_FP_DIR_ADDR, 16'h000F);
      wrw(`MPG_SP_DIR_ADDR, 16'h0000);
      repeat (12) @(posedge clk);
      #1;
      check({12'h000, cap1}, 16'h000A);
      check({8'h00, cap2}, 16'h005A);
      $display("test capture done");
   endtask : t_capture
   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (3000) @(posedge clk);
      num_errors++;
      close_out();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_wide();
      t_first();
      t_second();
      t_capture();
      close_out();
   end
endmodule : tb_mpg_gpio
`default_nettype wire
